/* File: logic/adcfe_pkg.sv */
package adcfe_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RES_W  = 12;
    localparam int CTRL_W = 8;
    localparam int CC_W   = 4;
    localparam int CHAN_N = 4;
    localparam int NEG_N  = 5;

    // ------------------------------------------------------------------
    // Control byte field positions
    // ------------------------------------------------------------------
    localparam int CFG_START   = 7;
    localparam int CFG_SEL_HI  = 6;
    localparam int CFG_SEL_MID = 5;
    localparam int CFG_SEL_LO  = 4;
    localparam int CFG_UNI     = 3;
    localparam int CFG_SGL     = 2;
    localparam int CFG_PD1     = 1;
    localparam int CFG_PD0     = 0;

    // ------------------------------------------------------------------
    // Bit counts of the control byte (bits already captured)
    // ------------------------------------------------------------------
    localparam logic [2:0] N_START    = 3'h1;
    localparam logic [2:0] N_SEL_DONE = 3'h3;
    localparam logic [2:0] N_TRACK    = 3'h5;
    localparam logic [2:0] N_LAST     = 3'h7;

    // ------------------------------------------------------------------
    // Conversion step counter values (serial clock cycles)
    // ------------------------------------------------------------------
    localparam logic [CC_W-1:0] CC_IDLE    = 4'h0;
    localparam logic [CC_W-1:0] CC_STROBE  = 4'h1;
    localparam logic [CC_W-1:0] CC_FIRST   = 4'h2;
    localparam logic [CC_W-1:0] CC_RESTART = 4'h8;
    localparam logic [CC_W-1:0] CC_LAST    = 4'hd;
    localparam logic [CC_W-1:0] CC_DONE    = 4'he;

    // ------------------------------------------------------------------
    // Channel select codes and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_A = 3'h1;
    localparam logic [2:0] SEL_B = 3'h5;
    localparam logic [2:0] SEL_C = 3'h2;
    localparam logic [2:0] SEL_D = 3'h6;
    localparam int         NEG_COM  = 4;
    localparam logic [RES_W-1:0] SAR_INIT = 12'h800;
    localparam logic [RES_W-1:0] RES_RST  = 12'h000;
    localparam logic [2:0]       SHUTDOWN_N_PIPE_RST = 3'h7;

    typedef enum logic {RX_IDLE, RX_CTRL} adcfe_rx_e;

    typedef struct packed {
        adcfe_rx_e        rx;
        logic [2:0]       n;
        logic [6:0]       sh;
        logic [2:0]       sel;
        logic [7:0]       cfg;
        logic [CC_W-1:0]  cc;
        logic             strobe;
        logic             dout;
        logic             tog;
        logic [RES_W-1:0] res;
        logic [1:0]       shd;
    } adcfe_link_s;

    typedef struct packed {
        logic [2:0]       shutdown_n_pipe;
        logic             shutdown_n_lvl;
        logic [2:0]       tog_sync;
        logic [1:0]       busy_sync;
        logic [RES_W-1:0] data;
        logic             valid;
    } adcfe_sys_s;

    typedef struct packed {
        logic [RES_W-1:0] trial;
        logic [RES_W-1:0] result;
    } adcfe_sar_s;

    typedef struct packed {
        logic              track;
        logic              on_neg;
        logic [CHAN_N-1:0] pos;
        logic [NEG_N-1:0]  neg;
    } adcfe_fall_s;

endpackage : adcfe_pkg

/* File: logic/adcfe_conv_if.sv */
interface adcfe_conv_if;
    import adcfe_pkg::*;

    logic                     load;
    logic                     step;
    logic [3:0]               bit_idx;
    logic                     comp;
    logic [RES_W-1:0]         trial;
    logic [RES_W-1:0]         result;
    logic                     track_req;
    logic                     conv_req;
    logic [2:0]               sel;
    logic                     sgl;
    logic                     track;
    logic                     on_neg;
    logic [CHAN_N-1:0]        pos;
    logic [NEG_N-1:0]         neg;

    modport ctl  (output load, step, bit_idx, comp, track_req, conv_req,
                  sel, sgl,
                  input  trial, result, track, on_neg, pos, neg);
    modport sar  (input  load, step, bit_idx, comp,
                  output trial, result);
    modport fall (input  track_req, conv_req, sel, sgl,
                  output track, on_neg, pos, neg);

endinterface : adcfe_conv_if

/* File: logic/adcfe_sar.sv */
module adcfe_sar (
    input  wire logic sclk,
    input  wire logic nrst,
    adcfe_conv_if.sar cv
);
    import adcfe_pkg::*;

    adcfe_sar_s s_reg;
    adcfe_sar_s s_next;

    // ------------------------------------------------------------------
    // Successive approximation register
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (cv.load) begin
            s_next.trial  = SAR_INIT;
            s_next.result = RES_RST;
        end else if (cv.step) begin
            for (int b = 0; b < RES_W; b++) begin
                if (b == int'(cv.bit_idx)) begin
                    s_next.result[b] = cv.comp;
                    s_next.trial[b]  = cv.comp;
                end
                if (b + 1 == int'(cv.bit_idx)) begin
                    s_next.trial[b] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{trial: RES_RST, result: RES_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign cv.trial  = s_reg.trial;
    assign cv.result = s_reg.result;

endmodule : adcfe_sar

/* File: logic/adcfe_fall.sv */
module adcfe_fall (
    input  wire logic  sclk,
    input  wire logic  nrst,
    adcfe_conv_if.fall cv
);
    import adcfe_pkg::*;

    adcfe_fall_s f_reg;
    adcfe_fall_s f_next;

    // ------------------------------------------------------------------
    // Track/hold and multiplexer control, moved on the falling edge
    // ------------------------------------------------------------------
    always_comb begin
        f_next        = f_reg;
        f_next.track  = cv.track_req;
        f_next.on_neg = cv.conv_req && !cv.track_req;
        f_next.pos    = '0;
        f_next.neg    = '0;
        case (cv.sel)
            SEL_A: begin
                f_next.pos[0] = 1'b1;
                if (cv.sgl) f_next.neg[NEG_COM] = 1'b1;
                else        f_next.neg[1] = 1'b1;
            end
            SEL_B: begin
                f_next.pos[1] = 1'b1;
                if (cv.sgl) f_next.neg[NEG_COM] = 1'b1;
                else        f_next.neg[0] = 1'b1;
            end
            SEL_C: begin
                f_next.pos[2] = 1'b1;
                if (cv.sgl) f_next.neg[NEG_COM] = 1'b1;
                else        f_next.neg[3] = 1'b1;
            end
            SEL_D: begin
                f_next.pos[3] = 1'b1;
                if (cv.sgl) f_next.neg[NEG_COM] = 1'b1;
                else        f_next.neg[2] = 1'b1;
            end
            default: begin
                f_next.pos = '0;
            end
        endcase
    end

    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            f_reg <= '{track: 1'b0, on_neg: 1'b0, pos: '0, neg: '0};
        end else begin
            f_reg <= f_next;
        end
    end

    assign cv.track  = f_reg.track;
    assign cv.on_neg = f_reg.on_neg;
    assign cv.pos    = f_reg.pos;
    assign cv.neg    = f_reg.neg;

endmodule : adcfe_fall

/* File: logic/adcfe_top.sv */
// Operation
// - Serial data output changes on the serial clock rising edge.
// - Serial data input is captured on the serial clock rising edge.
// - With chip select high, the data input is ignored entirely.
// - With chip select high, data and strobe outputs are high impedance.
// - Strobe is high one serial clock period just before the MSB.
// - Shutdown input low forces shutdown and stops any conversion.
// - Serial clock shifts data and paces every conversion step.
// - Each result is a 12-bit successive approximation of the sample.
// - Single-ended: selected channel positive, common pin negative.
// - Differential pairs are only channel 0 with 1, 2 with 3.
// - Only the positive input is sampled onto the hold capacitor.
// - Acquisition lasts three serial clock cycles.
// - Hold begins on the falling edge after the last control bit.
// - Conversion moves the hold capacitor to the negative input.
// - Single-ended codes 001,101,010,110 pick channels 0,1,2,3.
// - Differential codes 001,010,101,110 pick 0-1, 2-3, 1-0, 3-2.
// - Leading zeros are skipped; the first one starts the control byte, unless it comes before bit 6 of a running result leaves the output.
// - Tracking begins on the falling edge after the fifth bit.
// - Twelve result bits follow the strobe on rising edges, MSB first.
module adcfe_top (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          sdata_in,
    output logic                               sdata_out,
    output logic                               sdata_oe,
    output logic                               serial_strobe_out,
    output logic                               serial_strobe_oe,
    input  wire logic                          shutdown_n,
    input  wire logic                          comp_in,
    output logic [adcfe_pkg::RES_W-1:0]        dac_code,
    output logic [adcfe_pkg::CHAN_N-1:0]       hold_capacitor_pos,
    output logic [adcfe_pkg::NEG_N-1:0]        hold_capacitor_neg,
    output logic                               th_track,
    output logic                               hold_on_neg,
    output logic                               bipolar_mode,
    output logic                               single_diff_select,
    output logic [1:0]                         power_mode,
    output logic                               power_down,
    output logic                               conv_busy,
    output logic [adcfe_pkg::RES_W-1:0]        result_data,
    output logic                               result_valid
);
    import adcfe_pkg::*;

    adcfe_link_s  l_reg;
    adcfe_link_s  l_next;
    adcfe_sys_s   m_reg;
    adcfe_sys_s   m_next;
    adcfe_conv_if cv ();

    logic         shd_now;
    logic         step_now;
    logic         start_ok;
    logic         last_bit;

    // ------------------------------------------------------------------
    // Leaf modules
    // ------------------------------------------------------------------
    adcfe_sar u_sar (
        .sclk (sclk),
        .nrst (nrst),
        .cv   (cv.sar)
    );

    adcfe_fall u_fall (
        .sclk (sclk),
        .nrst (nrst),
        .cv   (cv.fall)
    );

    // ------------------------------------------------------------------
    // Link domain helpers
    // ------------------------------------------------------------------
    assign shd_now  = l_reg.shd[1];
    assign step_now = !shd_now && (l_reg.cc >= CC_FIRST)
                      && (l_reg.cc <= CC_LAST);
    // A new start bit is only recognised once bit 6 has left the output
    assign start_ok = (l_reg.cc == CC_IDLE) || (l_reg.cc >= CC_RESTART);
    assign last_bit = !shd_now && !cs_n && (l_reg.rx == RX_CTRL)
                      && (l_reg.n == N_LAST);

    // ------------------------------------------------------------------
    // Link domain: control byte receiver and result shifter
    // ------------------------------------------------------------------
    always_comb begin
        l_next        = l_reg;
        l_next.shd    = {l_reg.shd[0], m_reg.shutdown_n_lvl};
        l_next.strobe = 1'b0;
        l_next.dout   = 1'b0;
        if (shd_now) begin
            l_next.rx = RX_IDLE;
            l_next.n  = 3'h0;
            l_next.cc = CC_IDLE;
        end else begin
            // Output stage, paced by the serial clock
            case (l_reg.cc)
                CC_IDLE: begin
                    l_next.cc = CC_IDLE;
                end
                CC_STROBE: begin
                    l_next.strobe = 1'b1;
                    l_next.cc     = CC_FIRST;
                end
                CC_DONE: begin
                    l_next.res = cv.result;
                    l_next.tog = !l_reg.tog;
                    l_next.cc  = CC_IDLE;
                end
                default: begin
                    if (step_now) begin
                        l_next.dout = comp_in;
                        l_next.cc   = l_reg.cc + CC_STROBE;
                    end else begin
                        l_next.cc = CC_IDLE;
                    end
                end
            endcase
            // Receiver; nothing moves while chip select is high
            if (!cs_n) begin
                case (l_reg.rx)
                    RX_IDLE: begin
                        if (sdata_in && start_ok) begin
                            l_next.rx = RX_CTRL;
                            l_next.n  = N_START;
                            l_next.sh = 7'h01;
                        end
                    end
                    RX_CTRL: begin
                        l_next.sh = {l_reg.sh[5:0], sdata_in};
                        l_next.n  = l_reg.n + N_START;
                        if (l_reg.n == N_SEL_DONE) begin
                            l_next.sel = {l_reg.sh[1:0], sdata_in};
                        end
                        if (l_reg.n == N_LAST) begin
                            l_next.cfg = {l_reg.sh, sdata_in};
                            l_next.rx  = RX_IDLE;
                            l_next.n   = 3'h0;
                            l_next.cc  = CC_STROBE;
                        end
                    end
                    default: begin
                        l_next.rx = RX_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            l_reg <= '{rx: RX_IDLE, n: 3'h0, sh: 7'h00, sel: 3'h0,
                       cfg: 8'h00, cc: CC_IDLE, strobe: 1'b0,
                       dout: 1'b0, tog: 1'b0, res: RES_RST, shd: 2'h0};
        end else begin
            l_reg <= l_next;
        end
    end

    // ------------------------------------------------------------------
    // Conversion and multiplexer hookup
    // ------------------------------------------------------------------
    assign cv.load      = last_bit;
    assign cv.step      = step_now;
    assign cv.bit_idx   = CC_LAST - l_reg.cc;
    assign cv.comp      = comp_in;
    assign cv.track_req = (l_reg.rx == RX_CTRL)
                          && (l_reg.n >= N_TRACK);
    assign cv.conv_req  = (l_reg.cc != CC_IDLE) && !shd_now;
    assign cv.sel       = l_reg.sel;
    assign cv.sgl       = l_reg.cfg[CFG_SGL];

    // ------------------------------------------------------------------
    // System domain: shutdown filter and result hand-over
    // ------------------------------------------------------------------
    always_comb begin
        m_next           = m_reg;
        m_next.shutdown_n_pipe = {m_reg.shutdown_n_pipe[1:0], shutdown_n};
        if (m_reg.shutdown_n_pipe[1] == m_reg.shutdown_n_pipe[2]) begin
            m_next.shutdown_n_lvl = !m_reg.shutdown_n_pipe[2];
        end
        m_next.tog_sync  = {m_reg.tog_sync[1:0], l_reg.tog};
        m_next.busy_sync = {m_reg.busy_sync[0],
                            l_reg.cc != CC_IDLE};
        m_next.valid     = m_reg.tog_sync[1] ^ m_reg.tog_sync[2];
        if (m_reg.tog_sync[1] ^ m_reg.tog_sync[2]) begin
            m_next.data = l_reg.res;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            m_reg <= '{shutdown_n_pipe: SHUTDOWN_N_PIPE_RST, shutdown_n_lvl: 1'b0,
                       tog_sync: 3'h0, busy_sync: 2'h0,
                       data: RES_RST, valid: 1'b0};
        end else begin
            m_reg <= m_next;
        end
    end

    // ------------------------------------------------------------------
    // Pins and status
    // ------------------------------------------------------------------
    assign sdata_out          = l_reg.dout;
    assign sdata_oe           = !cs_n;
    assign serial_strobe_out  = l_reg.strobe;
    assign serial_strobe_oe   = !cs_n;
    assign dac_code           = cv.trial;
    assign hold_capacitor_pos = cv.pos;
    assign hold_capacitor_neg = cv.neg;
    assign th_track           = cv.track;
    assign hold_on_neg        = cv.on_neg;
    assign bipolar_mode       = !l_reg.cfg[CFG_UNI];
    assign single_diff_select = l_reg.cfg[CFG_SGL];
    assign power_mode         = {l_reg.cfg[CFG_PD1], l_reg.cfg[CFG_PD0]};
    assign power_down         = m_reg.shutdown_n_lvl;
    assign conv_busy          = m_reg.busy_sync[1];
    assign result_data        = m_reg.data;
    assign result_valid       = m_reg.valid;

endmodule : adcfe_top

/* File: bench/adcfe_top_properties.sv */
module adcfe_top_properties
    import adcfe_pkg::*;
(
    input wire logic             mclk,
    input wire logic             nrst,
    input wire logic             sclk,
    input wire logic             cs_n,
    input wire logic             sdata_out,
    input wire logic             sdata_oe,
    input wire logic             serial_strobe_out,
    input wire logic             serial_strobe_oe,
    input wire logic             shutdown_n,
    input wire logic             comp_in,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic [NEG_N-1:0] hold_capacitor_neg,
    input wire logic             th_track,
    input wire logic             hold_on_neg,
    input wire logic             single_diff_select,
    input wire logic             power_down
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------------------------------------------------
    // Serial port and sequencing properties
    // --------------------------------------------------------------
    sequence hold_after_track_s;
        th_track [*3] ##1 (!th_track && hold_on_neg);
    endsequence

    sequence msb_after_strobe_s;
        ##1 (sdata_out == $past(comp_in));
    endsequence

    oe_follow_cs_a: assert property (
        @(posedge sclk) disable iff (!nrst) sdata_oe == !cs_n &&
        serial_strobe_oe == !cs_n) else $error("enable differs from select");
    strobe_pulse_a: assert property (
        @(posedge sclk) disable iff (!nrst) $rose(serial_strobe_out) |=>
        !serial_strobe_out) else $error("strobe longer than one period");
    strobe_dac_a: assert property (
        @(posedge sclk) disable iff (!nrst) serial_strobe_out |->
        dac_code == SAR_INIT) else $error("first trial code wrong");
    msb_first_a: assert property (
        @(posedge sclk) disable iff (!nrst) serial_strobe_out |->
        msb_after_strobe_s) else $error("first bit is not the decision");
    result_tail_a: assert property (
        @(posedge sclk) disable iff (!nrst) serial_strobe_out |->
        ##13 !sdata_out) else $error("data out after the last bit");
    track_window_a: assert property (
        @(negedge sclk) disable iff (!nrst) $rose(th_track) |->
        hold_after_track_s) else $error("track window not three cycles");
    single_ended_a: assert property (
        @(negedge sclk) disable iff (!nrst) $rose(hold_on_neg) &&
        single_diff_select |-> hold_capacitor_neg == 5'h10)
        else $error("negative input is not the common pin");
    shutdown_a: assert property (
        @(posedge mclk) disable iff (!nrst) $fell(shutdown_n) |->
        ##[2:5] power_down) else $error("shutdown not entered");
endmodule : adcfe_top_properties

bind adcfe_top adcfe_top_properties u_props (
    .mclk, .nrst, .sclk, .cs_n, .sdata_out, .sdata_oe, .serial_strobe_out,
    .serial_strobe_oe, .shutdown_n, .comp_in, .dac_code, .hold_capacitor_neg,
    .th_track, .hold_on_neg, .single_diff_select, .power_down
);

/* File: bench/adcfe_host.sv */
module adcfe_host
    import adcfe_pkg::*;
(
    output logic                    sclk,
    output logic                    cs_n,
    output logic                    sdata_in,
    input  wire logic               sdata_out,
    input  wire logic               sdata_oe,
    input  wire logic               serial_strobe_out,
    input  wire logic               serial_strobe_oe,
    output logic                    comp_in,
    input  wire logic [RES_W-1:0]   dac_code,
    input  wire logic               th_track,
    input  wire logic [CHAN_N-1:0]  hold_capacitor_pos,
    input  wire logic [NEG_N-1:0]   hold_capacitor_neg
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------------------------------------------------------------
    // Serial master and analog input model
    // --------------------------------------------------------------
    logic [RES_W-1:0]  ain;
    logic              dline, sline, dprev, sprev;
    logic              dl [64], sl [64], tr [64];
    logic [CHAN_N-1:0] ps [64];
    logic [NEG_N-1:0]  ng [64];

    // Released lines show a level that changes every rising edge
    assign dline   = sdata_oe ? sdata_out : ~dprev;
    assign sline   = serial_strobe_oe ? serial_strobe_out : ~sprev;
    // Decision is high while the sample is at or above the trial code
    assign comp_in = ain >= dac_code;

    always @(posedge sclk) begin
        dprev <= dline;
        sprev <= sline;
    end

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdata_in = 1'b0;
        ain = '0;
        dprev = 1'b0;
        sprev = 1'b0;
    end

    // Clock stands low outside a frame; bits go out MSB first
    task automatic frame(input logic [63:0] bits, input int n,
                         input logic csel);
        #1.3 cs_n = csel;
        #3;
        for (int i = 1; i <= n; i++) begin
            sdata_in = bits[64-i];
            #3 sclk = 1'b1;
            #3;
            dl[i] = dline;
            sl[i] = sline;
            tr[i] = th_track;
            ps[i] = hold_capacitor_pos;
            ng[i] = hold_capacitor_neg;
            sclk = 1'b0;
        end
        #3 cs_n = 1'b1;
        sdata_in = 1'b0;
    endtask : frame
endmodule : adcfe_host

/* File: bench/adc_serial_front_end_test.sv */
module adc_serial_front_end_test;
    timeunit 1ns;
    timeprecision 100ps;
    import adcfe_pkg::*;
    // --------------------------------------------------------------
    // Stimulus table and checks
    // --------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  ss;
        logic [11:0] ain;
        logic [3:0]  pos;
        logic [4:0]  neg;
    } adcfe_row_s;

    // Listed select codes only, both input modes
    localparam adcfe_row_s ROWS [8] = '{
        '{4'h3, 12'h000, 4'h1, 5'h10}, '{4'hb, 12'hfff, 4'h2, 5'h10},
        '{4'h5, 12'h800, 4'h4, 5'h10}, '{4'hd, 12'h7ff, 4'h8, 5'h10},
        '{4'h2, 12'h001, 4'h1, 5'h02}, '{4'h4, 12'haaa, 4'h4, 5'h08},
        '{4'ha, 12'h555, 4'h2, 5'h01}, '{4'hc, 12'hffe, 4'h8, 5'h04}};

    logic              mclk, nrst, shutdown_n, sclk, cs_n, sdata_in, comp_in;
    logic              sdata_out, sdata_oe, serial_strobe_out, serial_strobe_oe;
    logic              th_track, hold_on_neg, single_diff_select, power_down;
    logic              result_valid, conv_busy, bipolar_mode;
    logic [1:0]        power_mode;
    logic [RES_W-1:0]  dac_code, result_data;
    logic [CHAN_N-1:0] hold_capacitor_pos;
    logic [NEG_N-1:0]  hold_capacitor_neg;
    int                error_cnt, n_tests, n_valid;

    adcfe_top dut (
        .mclk, .nrst, .sclk, .cs_n, .sdata_in, .sdata_out, .sdata_oe,
        .serial_strobe_out, .serial_strobe_oe, .shutdown_n, .comp_in,
        .dac_code, .hold_capacitor_pos, .hold_capacitor_neg, .th_track,
        .hold_on_neg, .bipolar_mode, .single_diff_select, .power_mode,
        .power_down, .conv_busy, .result_data, .result_valid);
    adcfe_host host (
        .sclk, .cs_n, .sdata_in, .sdata_out, .sdata_oe, .serial_strobe_out,
        .serial_strobe_oe, .comp_in, .dac_code, .th_track,
        .hold_capacitor_pos, .hold_capacitor_neg);

    task automatic cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_vec(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_vec

    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    function automatic logic [63:0] ctrl(input logic [3:0] ss);
        return {1'b1, ss[3:1], 1'b1, ss[0], 2'h3, 56'h0};
    endfunction : ctrl

    // One conversion whose start bit sits on edge s+1
    task automatic check_conv(input int s, input logic [11:0] a);
        cmp_bit(host.sl[s+8] | host.sl[s+10], 1'b0);
        cmp_bit(host.sl[s+9], 1'b1);
        for (int b = 0; b < 12; b++) begin
            cmp_bit(host.dl[s+10+b], a[11-b]);
        end
        cmp_bit(host.dl[s+22], 1'b0);
        for (int k = 5; k < 10; k++) begin
            cmp_bit(host.tr[s+k], k > 5 && k < 9);
        end
    endtask : check_conv

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (result_valid === 1'b1) n_valid++;
    end

    initial begin
        nrst = 1'b0;
        shutdown_n = 1'b1;
        error_cnt = 0;
        n_tests = 0;
        n_valid = 0;
        repeat (4) @(posedge mclk);
        cmp_bit(sdata_out | serial_strobe_out, 1'b0);
        cmp_bit(power_down, 1'b0);
        cmp_vec(result_data, 12'h000);
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        host.frame(ctrl(4'h3), 24, 1'b1);
        for (int i = 1; i <= 24; i++) begin
            cmp_bit(host.tr[i], 1'b0);
        end
        for (int r = 0; r < 8; r++) begin
            host.ain = ROWS[r].ain;
            host.frame(ctrl(ROWS[r].ss) >> r, r + 24, 1'b0);
            check_conv(r, ROWS[r].ain);
            cmp_vec(12'(host.ps[r+12]), 12'(ROWS[r].pos));
            cmp_vec(12'(host.ng[r+12]), 12'(ROWS[r].neg));
            repeat (6) @(posedge mclk);
            cmp_vec(result_data, ROWS[r].ain);
            cmp_bit(conv_busy, 1'b0);
            cmp_vec(12'({bipolar_mode, power_mode}), 12'h003);
        end
        host.ain = 12'h5a3;
        host.frame(ctrl(4'h3) | (ctrl(4'h4) >> 15) | (64'h1 << 52), 40, 1'b0);
        check_conv(0, 12'h5a3);
        check_conv(15, 12'h5a3);
        cmp_vec(12'(host.ps[27]), 12'h004);
        host.ain = 12'hfff;
        fork
            host.frame(ctrl(4'h3), 24, 1'b0);
            begin
                repeat (6) @(posedge mclk);
                shutdown_n <= 1'b0;
                repeat (4) @(posedge mclk);
                cmp_bit(conv_busy, 1'b1);
            end
        join
        cmp_bit(power_down, 1'b1);
        cmp_bit(host.dl[21], 1'b0);
        host.frame(ctrl(4'h3), 24, 1'b0);
        for (int i = 1; i <= 24; i++) begin
            cmp_bit(host.sl[i] | host.tr[i], 1'b0);
        end
        @(posedge mclk);
        shutdown_n <= 1'b1;
        repeat (8) @(posedge mclk);
        cmp_bit(power_down, 1'b0);
        host.frame(ctrl(4'h5) >> 4, 28, 1'b0);
        check_conv(4, 12'hfff);
        repeat (6) @(posedge mclk);
        cmp_vec(12'(n_valid), 12'h00b);
        finish_test();
    end
endmodule : adc_serial_front_end_test
